/* tb/spi_host.sv */
// behavioural serial host issuing register frames
`timescale 1ns/1ns
`default_nettype none
module spi_host (
    input wire logic clk,
    output logic sclk,
    output logic cs_n,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic sdo,
    input wire logic sdo_oe
);
    logic drv = 1'b0;
    logic [1:0] oe_seen = 2'b00;
    // shared line: the device's level while it drives, else the host's
    assign sdio_in = sdio_oe ? sdio_out : drv;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // ----------------------------------------
    // one bit slot: set up while low, taken on the rise
    // ----------------------------------------
    task automatic bit_slot(input logic b, input logic rel, output logic r);
        // released line toggles so a stale level cannot pass for data
        drv <= rel ? ~drv : b;
        repeat (6) @(posedge clk);
        r = (sdo & sdo_oe) | (sdio_out & sdio_oe);
        oe_seen = oe_seen | {sdo_oe, sdio_oe};
        sclk <= 1'b1;
        repeat (6) @(posedge clk);
        sclk <= 1'b0;
    endtask : bit_slot
    task automatic frame(input logic rd, input logic [14:0] addr, input int n,
                         input logic [15:0] wd, input logic lsb, output logic [15:0] rdat);
        logic [15:0] cmd;
        logic r;
        int idx;
        cmd = {rd, addr};
        oe_seen = 2'b00;
        rdat = 16'h0000;
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 15; i >= 0; i--) bit_slot(cmd[i], 1'b0, r);
        for (int k = 0; k < n; k++) begin
            for (int j = 0; j < 8; j++) begin
                idx = 15 - 8 * k - (lsb ? 7 - j : j);
                bit_slot(wd[idx], rd, r);
                rdat[idx] = r;
            end
        end
        repeat (6) @(posedge clk);
        cs_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : frame
endmodule : spi_host
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the serial port configuration block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic sclk, cs_n, sdio_in, sdio_out, sdio_oe, sdo, sdo_oe, soft_reset;
    logic [7:0] setup_a;
    logic [7:0] v;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    always #20 clk = ~clk;
    spi_port_interface_config u_spi_port_interface_config (.clk(clk), .reset_n(reset_n),
        .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .sdo(sdo), .sdo_oe(sdo_oe), .soft_reset(soft_reset), .setup_a(setup_a));
    spi_host u_spi_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo(sdo), .sdo_oe(sdo_oe));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic close_out;
        if (err_total == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    // whole run needs about 4800 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [14:0] a, input int n, input logic [15:0] d, input logic lsb);
        logic [15:0] t;
        u_spi_host.frame(1'b0, a, n, d, lsb, t);
    endtask : wr
    task automatic rd(input logic [14:0] a, input logic lsb, output logic [7:0] r);
        logic [15:0] t;
        u_spi_host.frame(1'b1, a, 1, 16'h0000, lsb, t);
        r = t[15:8];
    endtask : rd
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk("setup_a", 8'h00, setup_a);
        chk("outputs", 8'h00, {5'h00, soft_reset, sdo_oe, sdio_oe});
    endtask : t_reset
    task automatic t_four_wire_up;
        wr(15'h0000, 1, 16'h0c00, 1'b0);
        chk("setup_a", 8'h3c, setup_a);
        wr(15'h0004, 2, 16'ha53c, 1'b0);
        rd(15'h0005, 1'b0, v);
        chk("addr5", 8'h3c, v);
        chk("oe_seen", 8'h02, {6'h00, u_spi_host.oe_seen});
        rd(15'h0004, 1'b0, v);
        chk("addr4", 8'ha5, v);
        chk("sdo_oe idle", 8'h00, {7'h00, sdo_oe});
    endtask : t_four_wire_up
    task automatic t_three_wire_down;
        wr(15'h0000, 1, 16'h0000, 1'b0);
        chk("setup_a", 8'h00, setup_a);
        wr(15'h0009, 2, 16'h1122, 1'b0);
        rd(15'h0008, 1'b0, v);
        chk("addr8", 8'h22, v);
        chk("oe_seen", 8'h01, {6'h00, u_spi_host.oe_seen});
        rd(15'h0009, 1'b0, v);
        chk("addr9", 8'h11, v);
    endtask : t_three_wire_down
    task automatic t_bit_order;
        wr(15'h0000, 1, 16'h0200, 1'b0);
        chk("setup_a", 8'h42, setup_a);
        wr(15'h0003, 1, 16'h1e00, 1'b1);
        rd(15'h0003, 1'b1, v);
        chk("lsb read", 8'h1e, v);
        wr(15'h0000, 1, 16'h0000, 1'b1);
        rd(15'h0003, 1'b0, v);
        chk("msb read", 8'h1e, v);
    endtask : t_bit_order
    task automatic t_soft_reset;
        int cnt;
        logic [7:0] mid;
        cnt = 0;
        mid = 8'h00;
        fork
            wr(15'h0000, 1, 16'h0100, 1'b0);
            begin
                for (int i = 0; i < 2000 && soft_reset !== 1'b1; i++) @(posedge clk);
                while (soft_reset === 1'b1 && cnt < 50) begin
                    cnt++;
                    if (cnt == 2) mid = setup_a;
                    @(posedge clk);
                end
            end
        join
        chk("pulse len", 8'h04, 8'(cnt));
        chk("setup_a mid", 8'h81, mid);
        chk("setup_a after", 8'h00, setup_a);
        rd(15'h0003, 1'b0, v);
        chk("store cleared", 8'h00, v);
    endtask : t_soft_reset
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (10) @(posedge clk);
        t_reset();
        t_four_wire_up();
        t_three_wire_down();
        t_bit_order();
        t_soft_reset();
        close_out();
    end
endmodule : testbench
`default_nettype wire

/* verilog/reg_store.sv */
// small register memory with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "spi_cfg_params.svh"
module reg_store (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [`MEM_INDEX_BITS-1:0] wr_index,
    input wire logic [7:0] wr_data,
    input wire logic [`MEM_INDEX_BITS-1:0] rd_index,
    output logic [7:0] rd_data
);
    logic [7:0] mem [`MEM_WORDS];
    logic [7:0] next_rd_data;

    always_comb begin
        next_rd_data = mem[rd_index];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= 8'h00;
            for (int i = 0; i < `MEM_WORDS; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (clear) begin
            rd_data <= 8'h00;
            for (int i = 0; i < `MEM_WORDS; i++) begin
                mem[i] <= 8'h00;
            end
        end else begin
            rd_data <= next_rd_data;
            if (wr_en) begin
                mem[wr_index] <= wr_data;
            end
        end
    end
endmodule : reg_store
`default_nettype wire

/* verilog/spi_cfg_params.svh */
// constants for the serial port configuration block
`ifndef SPI_CFG_PARAMS_SVH
`define SPI_CFG_PARAMS_SVH
`define SETUP_A_ADDR 15'h0000
`define SETUP_A_RESET 8'h00
`define BIT_SOFT_RESET 0
`define BIT_LSB_FIRST 1
`define BIT_ADDR_ASCEND 2
`define BIT_FOUR_WIRE 3
`define RESET_PULSE_CYCLES 4'h4
`define ADDR_BITS 15
`define CMD_BITS 16
`define READ_FLAG_BIT 15
`define FRAME_CNT_MAX 5'h10
`define MEM_WORDS 16
`define MEM_INDEX_BITS 4
`endif

/* verilog/spi_cfg_pkg.sv */
// types for the serial port configuration block
`default_nettype none
package spi_cfg_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CMD = 4'h2,
        ST_DATA = 4'h4,
        ST_DONE = 4'h8
    } frame_state_e;
endpackage : spi_cfg_pkg
`default_nettype wire

/* verilog/spi_port_interface_config.sv */
// serial control port with its interface configuration register
//
// Notes on behaviour
// - writing one to bit 0 starts a soft reset; bit self-clears when done.
// - bit 1 set shifts data in and out lsb first, else msb first.
// - bit 2 set steps streaming addresses up, clear steps them down.
// - bit 3 set selects 4-wire mode, read data on the output line.
// - bits 7..4 read back copies of bits 0..3 in that order.
`timescale 1ns/1ns
`default_nettype none
`include "spi_cfg_params.svh"
module spi_port_interface_config (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic sdo,
    output logic sdo_oe,
    output logic soft_reset,
    output logic [7:0] setup_a
);
    // -------------------------------------------------------------
    // pin synchronisers: a change counts once stages two and three agree
    // -------------------------------------------------------------
    logic [2:0] sclk_s, cs_s, din_s;
    logic sclk_q, cs_q, din_q;
    logic [2:0] next_sclk_s, next_cs_s, next_din_s;
    logic next_sclk_q, next_cs_q, next_din_q;

    always_comb begin
        next_sclk_s = {sclk_s[1:0], sclk};
        next_cs_s = {cs_s[1:0], cs_n};
        next_din_s = {din_s[1:0], sdio_in};
        next_sclk_q = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_q;
        next_cs_q = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_q;
        next_din_q = (din_s[1] == din_s[2]) ? din_s[2] : din_q;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_s <= 3'h0;
            cs_s <= 3'h7;
            din_s <= 3'h0;
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
            din_q <= 1'b0;
        end else begin
            sclk_s <= next_sclk_s;
            cs_s <= next_cs_s;
            din_s <= next_din_s;
            sclk_q <= next_sclk_q;
            cs_q <= next_cs_q;
            din_q <= next_din_q;
        end
    end

    logic sclk_d;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_q;
        end
    end
    wire logic rise = sclk_q & ~sclk_d & ~cs_q;
    wire logic fall = ~sclk_q & sclk_d & ~cs_q;

    // -------------------------------------------------------------
    // frame engine
    // -------------------------------------------------------------
    spi_cfg_pkg::frame_state_e state, next_state;
    logic [4:0] cnt, next_cnt;
    logic [15:0] cmd, next_cmd;
    logic [7:0] shin, next_shin;
    logic [7:0] shout, next_shout;
    logic [`ADDR_BITS-1:0] addr, next_addr;
    logic rd, next_rd;
    logic [7:0] ctrl, next_ctrl;
    logic [3:0] rst_cnt, next_rst_cnt;
    logic sout, next_sout;
    logic s_oe, next_s_oe;
    logic d_oe, next_d_oe;
    logic soft_reset_q, next_soft_reset;
    logic mem_we;
    logic [7:0] mem_rd;
    logic [7:0] wbyte;

    wire logic lsb = ctrl[`BIT_LSB_FIRST];
    wire logic four = ctrl[`BIT_FOUR_WIRE];

    // register read value; mirrors occupy the upper nibble
    function automatic logic [7:0] read_value(input logic [`ADDR_BITS-1:0] a,
                                              input logic [7:0] c,
                                              input logic [7:0] m);
        if (a == `SETUP_A_ADDR) begin
            read_value = {c[0], c[1], c[2], c[3], c[3:0]};
        end else begin
            read_value = m;
        end
    endfunction : read_value

    // order a byte for shifting so bit 7 always goes out first
    function automatic logic [7:0] orient(input logic [7:0] b, input logic l);
        orient = l ? {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} : b;
    endfunction : orient

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_cmd = cmd;
        next_shin = shin;
        next_shout = shout;
        next_addr = addr;
        next_rd = rd;
        next_ctrl = ctrl;
        next_sout = sout;
        next_s_oe = s_oe;
        next_d_oe = d_oe;
        next_rst_cnt = rst_cnt;
        next_soft_reset = 1'b0;
        mem_we = 1'b0;
        wbyte = orient({shin[6:0], din_q}, lsb);
        if (rst_cnt != 4'h0) begin
            next_rst_cnt = rst_cnt - 4'h1;
            next_soft_reset = 1'b1;
            if (rst_cnt == 4'h1) begin
                next_ctrl[`BIT_SOFT_RESET] = 1'b0;
            end
        end
        if (cs_q) begin
            next_state = spi_spi_idle();
            next_cnt = 5'h00;
            next_s_oe = 1'b0;
            next_d_oe = 1'b0;
        end else begin
            unique case (state)
                spi_cfg_pkg::ST_IDLE: begin
                    next_state = spi_cfg_pkg::ST_CMD;
                    next_cnt = 5'h00;
                end
                spi_cfg_pkg::ST_CMD: begin
                    if (rise) begin
                        next_cmd = {cmd[14:0], din_q};
                        next_cnt = cnt + 5'h01;
                        if (cnt + 5'h01 == `FRAME_CNT_MAX) begin
                            next_rd = cmd[14];
                            next_addr = {cmd[13:0], din_q};
                            next_cnt = 5'h00;
                            next_state = spi_cfg_pkg::ST_DATA;
                        end
                    end
                end
                spi_cfg_pkg::ST_DATA: begin
                    // load only while the clock is still high; after the first
                    // fall of a byte a reload would undo the shift
                    if (rd && cnt == 5'h00 && !rise && !fall && sclk_q) begin
                        next_shout = orient(read_value(addr, ctrl, mem_rd), lsb);
                    end
                    if (fall && rd) begin
                        next_sout = shout[7];
                        next_shout = {shout[6:0], 1'b0};
                        next_s_oe = ~four;
                        next_d_oe = four;
                    end
                    if (rise) begin
                        next_shin = {shin[6:0], din_q};
                        next_cnt = cnt + 5'h01;
                        if (cnt == 5'h07) begin
                            next_cnt = 5'h00;
                            if (!rd) begin
                                mem_we = (addr != `SETUP_A_ADDR);
                                if (addr == `SETUP_A_ADDR) begin
                                    next_ctrl = {4'h0, wbyte[3:0]};
                                    if (wbyte[`BIT_SOFT_RESET]) begin
                                        next_rst_cnt = `RESET_PULSE_CYCLES;
                                    end
                                end
                            end
                            next_addr = ctrl[`BIT_ADDR_ASCEND] ? addr + 15'h0001
                                                               : addr - 15'h0001;
                        end
                    end
                end
                spi_cfg_pkg::ST_DONE: begin
                    next_state = spi_cfg_pkg::ST_DONE;
                end
                default: begin
                    next_state = spi_cfg_pkg::ST_IDLE;
                end
            endcase
        end
    end

    function automatic spi_cfg_pkg::frame_state_e spi_spi_idle();
        spi_spi_idle = spi_cfg_pkg::ST_IDLE;
    endfunction : spi_spi_idle

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= spi_cfg_pkg::ST_IDLE;
            cnt <= 5'h00;
            cmd <= 16'h0000;
            shin <= 8'h00;
            shout <= 8'h00;
            addr <= 15'h0000;
            rd <= 1'b0;
            ctrl <= `SETUP_A_RESET;
            rst_cnt <= 4'h0;
            sout <= 1'b0;
            s_oe <= 1'b0;
            d_oe <= 1'b0;
            soft_reset_q <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            cmd <= next_cmd;
            shin <= next_shin;
            shout <= next_shout;
            addr <= next_addr;
            rd <= next_rd;
            ctrl <= next_ctrl;
            rst_cnt <= next_rst_cnt;
            sout <= next_sout;
            s_oe <= next_s_oe;
            d_oe <= next_d_oe;
            soft_reset_q <= next_soft_reset;
        end
    end

    // -------------------------------------------------------------
    // other registers; cleared by the soft reset pulse
    // -------------------------------------------------------------
    reg_store u_store (
        .clk(clk),
        .reset_n(reset_n),
        .clear(soft_reset_q),
        .wr_en(mem_we),
        .wr_index(addr[`MEM_INDEX_BITS-1:0]),
        .wr_data(wbyte),
        .rd_index(addr[`MEM_INDEX_BITS-1:0]),
        .rd_data(mem_rd)
    );

    // -------------------------------------------------------------
    // outputs, all registered
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sdio_out <= 1'b0;
            sdio_oe <= 1'b0;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
            soft_reset <= 1'b0;
            setup_a <= `SETUP_A_RESET;
        end else begin
            sdio_out <= next_sout;
            sdio_oe <= next_s_oe;
            sdo <= next_sout;
            sdo_oe <= next_d_oe;
            soft_reset <= next_soft_reset;
            setup_a <= read_value(`SETUP_A_ADDR, next_ctrl, 8'h00);
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_reset_self_clear: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(soft_reset) |-> ##[1:8] !ctrl[`BIT_SOFT_RESET])
        else $error("soft reset bit did not clear");
    a_reset_pulse_on: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl[`BIT_SOFT_RESET] && rst_cnt != 4'h0 |=> soft_reset)
        else $error("soft reset not driven");
    a_mirror_bits: assert property (@(posedge clk) disable iff (!reset_n)
        setup_a[7:4] == {setup_a[0], setup_a[1], setup_a[2], setup_a[3]})
        else $error("mirror bits wrong");
    a_four_wire_line: assert property (@(posedge clk) disable iff (!reset_n)
        sdo_oe |-> ctrl[`BIT_FOUR_WIRE] && !sdio_oe)
        else $error("4-wire drive wrong");
    a_three_wire_line: assert property (@(posedge clk) disable iff (!reset_n)
        sdio_oe |-> !ctrl[`BIT_FOUR_WIRE] && !sdo_oe)
        else $error("3-wire drive wrong");
    a_addr_step_up: assert property (@(posedge clk) disable iff (!reset_n)
        state == spi_cfg_pkg::ST_DATA && rise && cnt == 5'h07 && !cs_q
        && ctrl[`BIT_ADDR_ASCEND] |=> addr == $past(addr) + 15'h0001)
        else $error("address not stepped up");
    a_addr_step_down: assert property (@(posedge clk) disable iff (!reset_n)
        state == spi_cfg_pkg::ST_DATA && rise && cnt == 5'h07 && !cs_q
        && !ctrl[`BIT_ADDR_ASCEND] |=> addr == $past(addr) - 15'h0001)
        else $error("address not stepped down");
    a_order_lsb: assert property (@(posedge clk) disable iff (!reset_n)
        state == spi_cfg_pkg::ST_DATA && rise && cnt == 5'h07 && !rd && lsb
        && addr == `SETUP_A_ADDR |=> ctrl[`BIT_FOUR_WIRE] == $past(shin[3]))
        else $error("lsb first order wrong");
endmodule : spi_port_interface_config
`default_nettype wire
